// ---- src/urx_pkg.sv ----
// shared constants and carrier types of the receive endpoint control block
package urx_pkg;

    // register indices as printed, byte address is four times the index
    localparam logic [31:0] MAXP_IDX  = 32'h0000_0114;
    localparam logic [31:0] CSRL_IDX  = 32'h0000_0116;
    localparam logic [31:0] CSRH_IDX  = 32'h0000_0117;
    localparam logic [31:0] CFG_IDX   = 32'h0000_0140;
    localparam logic [31:0] IDX_SCALE = 32'h0000_0004;
    localparam logic [31:0] MAXP_ADDR = MAXP_IDX * IDX_SCALE;
    localparam logic [31:0] CSRL_ADDR = CSRL_IDX * IDX_SCALE;
    localparam logic [31:0] CSRH_ADDR = CSRH_IDX * IDX_SCALE;
    localparam logic [31:0] CFG_ADDR  = CFG_IDX * IDX_SCALE;

    // low control byte fields
    localparam int B_TCLR   = 7;
    localparam int B_STALL  = 6;
    localparam int B_REQ    = 5;
    localparam int B_FLUSH  = 4;
    localparam int B_ERR3   = 3;
    localparam int B_RETRY  = 2;
    localparam int B_FULL   = 1;
    localparam int B_RDY    = 0;
    localparam logic [7:0] CSRL_RST = 8'h00;

    // high control byte fields
    localparam int H_AUTO_READY_CLEAR = 7;
    localparam int H_AUTO_IN_REQUEST  = 6;
    localparam int H_DT      = 1;

    // configuration word fields
    localparam int C_HOST    = 0;
    localparam int C_ISO     = 1;
    localparam int C_NAK_LO  = 8;
    localparam int C_NAK_HI  = 15;

    // widths and limits
    localparam int MAXP_W = 11;
    localparam int CNT_W  = 9;
    localparam logic [CNT_W-1:0] RETRY_LIMIT = 9'h003;
    localparam logic [CNT_W-1:0] CNT_ONE     = 9'h001;
    localparam logic [1:0]       HTRANS_NSEQ = 2'h2;
    localparam logic             HRESP_OKAY  = 1'h0;

    // events from the usb engine, each pulse lasts one cycle
    typedef struct packed {
        logic              rx_pkt;
        logic              rx_crc_err;
        logic              rx_short;
        logic              stall_rcvd;
        logic              stall_sent;
        logic              nak_rcvd;
        logic              no_data;
        logic              toggle_flip;
        logic              unload_done;
        logic [MAXP_W-1:0] unload_len;
        logic              fifo_full;
    } urx_evt_t;

    // controls toward the usb engine
    typedef struct packed {
        logic              in_request;
        logic              send_stall;
        logic              halted;
        logic              flush;
        logic              toggle_clear;
        logic              data_toggle;
        logic              ep_event;
        logic [MAXP_W-1:0] max_payload;
    } urx_ctl_t;

endpackage

// ---- src/urx_evt_cnt.sv ----
// saturating event counter that pulses once when a limit is reached
`timescale 1ns/1ns
module urx_evt_cnt (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     clear,
    input  wire logic                     inc,
    input  wire logic [urx_pkg::CNT_W-1:0] limit,
    output logic                          hit
);

    logic [urx_pkg::CNT_W-1:0] cnt_r;
    logic [urx_pkg::CNT_W-1:0] cnt_nxt;
    logic                      done_r;
    logic                      done_nxt;
    logic [urx_pkg::CNT_W-1:0] cnt_inc;

    // a zero limit never fires; a hit in the cycle of a clear still gets out
    always_comb begin
        cnt_inc  = cnt_r + urx_pkg::CNT_ONE;
        hit      = inc & ~done_r & (limit != '0) & (cnt_inc == limit); // RQ20
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (clear) begin
            cnt_nxt  = '0;
            done_nxt = 1'b0;
        end else if (inc && !done_r) begin
            cnt_nxt  = cnt_inc;
            done_nxt = hit;
        end
    end

    // count state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

endmodule

// ---- src/urx_rx_ep_ctrl.sv ----
// receive endpoint control and status byte with ahb-lite register access
//
// Contract
// RQ1 - writing one to bit 7 resets the receive data toggle, both roles
// RQ2 - host: received STALL sets bit 6 and the endpoint event flag
// RQ3 - host: writing bit 5 requests IN; cleared when packet-ready sets
// RQ4 - writing bit 4 drops next packet, resets pointer, clears packet-ready
// RQ5 - double-buffered FIFO may need the discard command issued twice
// RQ6 - software discards only while packet-ready is set
// RQ7 - isochronous: bit 3 flags crc or stuff error, cleared with ready
// RQ8 - bulk host: bit 3 set and endpoint halted past the NAK limit
// RQ9 - host: three attempts without data set bit 2 and event flag
// RQ10 - bit 2 reads zero on an isochronous endpoint
// RQ11 - bit 1 is a read-only FIFO full indication
// RQ12 - received data packet sets bit 0 and the endpoint event flag
// RQ13 - auto-clear drops packet-ready after a full max-payload unload
// RQ14 - software clears packet-ready by hand otherwise
// RQ15 - device: transmitted STALL sets bit 6, software clears it
// RQ16 - device: bit 5 makes the endpoint STALL until software clears it
// RQ17 - send-stall has no effect on an isochronous endpoint
// RQ18 - the low control byte is eight bits and resets to zero
// RQ19 - auto-request sets the IN request whenever packet-ready clears
// RQ20 - a hardware set beats a simultaneous software clear
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ns
module urx_rx_ep_ctrl (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire urx_pkg::urx_evt_t evt,
    output urx_pkg::urx_ctl_t     ctl
);

    // bus state
    logic        wr_pend_r;
    logic        wr_pend_nxt;
    logic [31:0] waddr_r;
    logic [31:0] waddr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        sel_ok;

    // register state
    logic [7:0]                  csrl_r;
    logic [7:0]                  csrl_nxt;
    logic                        auto_ready_clear_r;
    logic                        auto_ready_clear_nxt;
    logic                        auto_in_request_r;
    logic                        auto_in_request_nxt;
    logic                        dt_r;
    logic                        dt_nxt;
    logic [urx_pkg::MAXP_W-1:0]  maxp_r;
    logic [urx_pkg::MAXP_W-1:0]  maxp_nxt;
    logic                        host_r;
    logic                        host_nxt;
    logic                        iso_r;
    logic                        iso_nxt;
    logic [7:0]                  naklim_r;
    logic [7:0]                  naklim_nxt;

    // command pulses toward the engine
    logic flush_r;
    logic flush_nxt;
    logic tclr_r;
    logic tclr_nxt;
    logic epev_r;
    logic epev_nxt;

    // decoded write strobes and helper terms
    logic                     we_csrl;
    logic                     we_csrh;
    logic                     we_maxp;
    logic                     we_cfg;
    logic [7:0]               wd;
    logic                     rdy_set;
    logic                     rdy_clr;
    logic                     rdy_fall;
    logic                     auto_clr;
    logic                     stall_set;
    logic                     err3_set;
    logic                     retry_set;
    logic                     nak_hit;
    logic                     retry_hit;
    logic                     nak_inc;
    logic                     nak_clear;
    logic                     retry_inc;
    logic                     retry_clear;
    logic [urx_pkg::CNT_W-1:0] nak_limit;

    // true when the given address, of a read in address phase or a write in data phase, equals the given byte address
    function automatic logic hit_addr(input logic [31:0] a, input logic [31:0] ref_a);
        hit_addr = (a == ref_a);
    endfunction

    // low byte as software sees it, command bits read back as zero
    function automatic logic [7:0] csrl_view(input logic [7:0] c,
                                             input logic       iso,
                                             input logic       full);
        logic [7:0] v;
        v                  = c;
        v[urx_pkg::B_TCLR] = 1'b0;
        v[urx_pkg::B_FLUSH] = 1'b0;
        v[urx_pkg::B_FULL] = full; // RQ11
        if (iso) begin
            v[urx_pkg::B_RETRY] = 1'b0; // RQ10
        end
        csrl_view = v;
    endfunction

    // zero-wait slave: always ready, always okay
    // a read right behind a write to the same register returns the old value
    assign hreadyout = 1'b1;
    assign hresp     = urx_pkg::HRESP_OKAY;
    assign hrdata    = rdata_r;
    assign sel_ok    = hsel & hready & (htrans == urx_pkg::HTRANS_NSEQ);

    // address phase capture and read data mux, unmapped reads give zero
    always_comb begin
        wr_pend_nxt = sel_ok & hwrite;
        waddr_nxt   = sel_ok ? haddr : waddr_r;
        rdata_nxt   = rdata_r;
        if (sel_ok && !hwrite) begin
            rdata_nxt = 32'h0000_0000;
            if (hit_addr(haddr, urx_pkg::CSRL_ADDR)) begin
                rdata_nxt[7:0] = csrl_view(csrl_r, iso_r, evt.fifo_full);
            end else if (hit_addr(haddr, urx_pkg::CSRH_ADDR)) begin
                rdata_nxt[urx_pkg::H_AUTO_READY_CLEAR] = auto_ready_clear_r;
                rdata_nxt[urx_pkg::H_AUTO_IN_REQUEST]  = auto_in_request_r;
                rdata_nxt[urx_pkg::H_DT]      = dt_r;
            end else if (hit_addr(haddr, urx_pkg::MAXP_ADDR)) begin
                rdata_nxt[urx_pkg::MAXP_W-1:0] = maxp_r;
            end else if (hit_addr(haddr, urx_pkg::CFG_ADDR)) begin
                rdata_nxt[urx_pkg::C_HOST] = host_r;
                rdata_nxt[urx_pkg::C_ISO]  = iso_r;
                rdata_nxt[urx_pkg::C_NAK_HI:urx_pkg::C_NAK_LO] = naklim_r;
            end
        end
    end

    // write strobes act in the data phase with hwdata
    always_comb begin
        we_csrl = wr_pend_r & hit_addr(waddr_r, urx_pkg::CSRL_ADDR);
        we_csrh = wr_pend_r & hit_addr(waddr_r, urx_pkg::CSRH_ADDR);
        we_maxp = wr_pend_r & hit_addr(waddr_r, urx_pkg::MAXP_ADDR);
        we_cfg  = wr_pend_r & hit_addr(waddr_r, urx_pkg::CFG_ADDR);
        wd      = hwdata[7:0];
    end

    // retry and nak counting only matter for a host on a non-iso endpoint
    always_comb begin
        nak_limit   = {1'b0, naklim_r} + urx_pkg::CNT_ONE;
        nak_inc     = evt.nak_rcvd & host_r & ~iso_r & csrl_r[urx_pkg::B_REQ];
        nak_clear   = evt.rx_pkt | (we_csrl & ~wd[urx_pkg::B_ERR3]);
        retry_inc   = evt.no_data & host_r & ~iso_r;
        retry_clear = evt.rx_pkt | evt.stall_rcvd | (we_csrl & ~wd[urx_pkg::B_RETRY]);
    end

    // nak responses beyond the programmed limit
    urx_evt_cnt u_nak_cnt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (nak_clear),
        .inc     (nak_inc),
        .limit   (nak_limit),
        .hit     (nak_hit)
    );

    // receive attempts that brought no data
    urx_evt_cnt u_retry_cnt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (retry_clear),
        .inc     (retry_inc),
        .limit   (urx_pkg::RETRY_LIMIT),
        .hit     (retry_hit)
    );

    // packet-ready: hardware set wins over every clear source
    always_comb begin
        rdy_set  = evt.rx_pkt; // RQ12
        auto_clr = evt.unload_done & auto_ready_clear_r & (evt.unload_len == maxp_r); // RQ13
        rdy_clr  = (we_csrl & ~wd[urx_pkg::B_RDY]) | (we_csrl & wd[urx_pkg::B_FLUSH])
                   | auto_clr; // RQ4
        rdy_fall = csrl_r[urx_pkg::B_RDY] & rdy_clr & ~rdy_set;
    end

    // status set sources by role and transfer type
    always_comb begin
        stall_set = host_r ? evt.stall_rcvd : evt.stall_sent; // RQ2 RQ15
        if (iso_r) begin
            err3_set = evt.rx_pkt & evt.rx_crc_err; // RQ7
        end else begin
            err3_set = nak_hit; // RQ8
        end
        retry_set = retry_hit; // RQ9
    end

    // low control byte next value
    always_comb begin
        csrl_nxt = csrl_r;
        // software writes only clear the sticky flags
        if (we_csrl) begin
            csrl_nxt[urx_pkg::B_STALL] = csrl_r[urx_pkg::B_STALL] & wd[urx_pkg::B_STALL];
            csrl_nxt[urx_pkg::B_ERR3]  = csrl_r[urx_pkg::B_ERR3] & wd[urx_pkg::B_ERR3];
            csrl_nxt[urx_pkg::B_RETRY] = csrl_r[urx_pkg::B_RETRY] & wd[urx_pkg::B_RETRY];
            csrl_nxt[urx_pkg::B_REQ]   = wd[urx_pkg::B_REQ]; // RQ3 RQ16
        end
        csrl_nxt[urx_pkg::B_RDY] = rdy_set | (csrl_r[urx_pkg::B_RDY] & ~rdy_clr); // RQ20
        if (stall_set) begin
            csrl_nxt[urx_pkg::B_STALL] = 1'b1; // RQ20
        end
        // error flag of an iso endpoint follows packet-ready down
        if (iso_r && rdy_fall) begin
            csrl_nxt[urx_pkg::B_ERR3] = 1'b0; // RQ7
        end
        if (err3_set) begin
            csrl_nxt[urx_pkg::B_ERR3] = 1'b1; // RQ20
        end
        if (retry_set) begin
            csrl_nxt[urx_pkg::B_RETRY] = 1'b1; // RQ9
        end
        // in host role bit 5 is the in request, in device role the stall order
        if (host_r) begin
            if (rdy_set) begin
                csrl_nxt[urx_pkg::B_REQ] = 1'b0; // RQ3
            end else if (rdy_fall && auto_in_request_r) begin
                csrl_nxt[urx_pkg::B_REQ] = 1'b1; // RQ19
            end
        end
        csrl_nxt[urx_pkg::B_TCLR]  = 1'b0;
        csrl_nxt[urx_pkg::B_FLUSH] = 1'b0;
        csrl_nxt[urx_pkg::B_FULL]  = 1'b0;
    end

    // high byte, payload size and role configuration
    always_comb begin
        auto_ready_clear_nxt = auto_ready_clear_r;
        auto_in_request_nxt  = auto_in_request_r;
        maxp_nxt    = maxp_r;
        host_nxt    = host_r;
        iso_nxt     = iso_r;
        naklim_nxt  = naklim_r;
        if (we_csrh) begin
            auto_ready_clear_nxt = wd[urx_pkg::H_AUTO_READY_CLEAR];
            auto_in_request_nxt  = wd[urx_pkg::H_AUTO_IN_REQUEST];
        end
        // a short packet ends auto-request, even against a write
        if (evt.rx_pkt && evt.rx_short) begin
            auto_in_request_nxt = 1'b0;
        end
        if (we_maxp) begin
            maxp_nxt = hwdata[urx_pkg::MAXP_W-1:0];
        end
        if (we_cfg) begin
            host_nxt   = hwdata[urx_pkg::C_HOST];
            iso_nxt    = hwdata[urx_pkg::C_ISO];
            naklim_nxt = hwdata[urx_pkg::C_NAK_HI:urx_pkg::C_NAK_LO];
        end
    end

    // data toggle: the reset command beats a flip in the same cycle
    always_comb begin
        tclr_nxt = we_csrl & wd[urx_pkg::B_TCLR]; // RQ1
        if (tclr_nxt) begin
            dt_nxt = 1'b0; // RQ1
        end else if (evt.toggle_flip) begin
            dt_nxt = ~dt_r;
        end else begin
            dt_nxt = dt_r;
        end
        flush_nxt = we_csrl & wd[urx_pkg::B_FLUSH]; // RQ4
        epev_nxt  = rdy_set | (host_r & evt.stall_rcvd) | retry_set; // RQ2 RQ9 RQ12
    end

    // bus phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            waddr_r   <= 32'h0000_0000;
            rdata_r   <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            waddr_r   <= waddr_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // register state, reset to documented zeros
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csrl_r    <= urx_pkg::CSRL_RST; // RQ18
            auto_ready_clear_r <= 1'b0;
            auto_in_request_r  <= 1'b0;
            dt_r      <= 1'b0;
            maxp_r    <= '0;
            host_r    <= 1'b0;
            iso_r     <= 1'b0;
            naklim_r  <= 8'h00;
        end else begin
            csrl_r    <= csrl_nxt;
            auto_ready_clear_r <= auto_ready_clear_nxt;
            auto_in_request_r  <= auto_in_request_nxt;
            dt_r      <= dt_nxt;
            maxp_r    <= maxp_nxt;
            host_r    <= host_nxt;
            iso_r     <= iso_nxt;
            naklim_r  <= naklim_nxt;
        end
    end

    // one-cycle command pulses toward the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flush_r   <= 1'b0;
            tclr_r    <= 1'b0;
            epev_r    <= 1'b0;
        end else begin
            flush_r   <= flush_nxt;
            tclr_r    <= tclr_nxt;
            epev_r    <= epev_nxt;
        end
    end

    // engine controls; a halted non-iso host endpoint stops requesting, an iso crc error does not stop it
    always_comb begin
        ctl.halted       = csrl_r[urx_pkg::B_ERR3] & host_r & ~iso_r; // RQ8
        ctl.in_request   = csrl_r[urx_pkg::B_REQ] & host_r & ~ctl.halted; // RQ3
        ctl.send_stall   = csrl_r[urx_pkg::B_REQ] & ~host_r & ~iso_r; // RQ16 RQ17
        ctl.flush        = flush_r; // RQ4
        ctl.toggle_clear = tclr_r; // RQ1
        ctl.data_toggle  = dt_r;
        ctl.ep_event     = epev_r;
        ctl.max_payload  = maxp_r;
    end

endmodule

// ---- dv/urx_rx_ep_ctrl_assertions.sv ----
// concurrent checks on the receive endpoint control block ports
`timescale 1ns/1ns
module urx_rx_ep_ctrl_assertions (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic [31:0]       hrdata,
    input wire urx_pkg::urx_evt_t evt,
    input wire urx_pkg::urx_ctl_t ctl
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic wr_q_r;
    logic wr_q_nxt;

    // marks the data phase of a write to the low control byte
    always_comb begin
        wr_q_nxt = hsel && hready && htrans == urx_pkg::HTRANS_NSEQ && hwrite
                   && haddr == urx_pkg::CSRL_ADDR;
    end

    // register only, no other logic here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q_r <= 1'b0;
        end else begin
            wr_q_r <= wr_q_nxt;
        end
    end

    a_flush_cmd: assert property (wr_q_r && hwdata[urx_pkg::B_FLUSH] |=> ctl.flush)
        else $error("flush write gave no flush pulse");
    a_flush_cause: assert property (ctl.flush |-> $past(wr_q_r) && $past(hwdata[urx_pkg::B_FLUSH]))
        else $error("flush pulse without a flush write");
    a_toggle_cmd: assert property (wr_q_r && hwdata[urx_pkg::B_TCLR]
        |=> ctl.toggle_clear && !ctl.data_toggle) else $error("toggle reset not applied");
    a_pkt_event: assert property (evt.rx_pkt |=> ctl.ep_event)
        else $error("packet without endpoint event");
    a_pkt_request: assert property (evt.rx_pkt |=> !ctl.in_request)
        else $error("in request kept after packet");
    a_halt_block: assert property (ctl.halted |-> !ctl.in_request)
        else $error("in request while halted");
    a_halt_hold: assert property (ctl.halted
        && !$past(hsel && hready && hwrite && htrans == urx_pkg::HTRANS_NSEQ) |=> ctl.halted)
        else $error("halt dropped without a write");
    a_stall_excl: assert property (ctl.send_stall |-> !ctl.halted && !ctl.in_request)
        else $error("send stall overlaps host controls");
    a_reset_idle: assert property ($rose(hresetn) |-> ctl == '0 && hrdata == 32'h0)
        else $error("outputs not idle after reset");
endmodule

bind urx_rx_ep_ctrl urx_rx_ep_ctrl_assertions u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt), .ctl(ctl)
);

// ---- dv/urx_usb_model.sv ----
// usb engine and far-side peer model answering endpoint requests
`timescale 1ns/1ns
module urx_usb_model (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire urx_pkg::urx_ctl_t ctl,
    output urx_pkg::urx_evt_t     evt
);
    logic [2:0]  mode    = 3'h0; // 0 silent, 1 data, 2 nak, 3 no data, 4 stall
    int          lat     = 1;    // answer delay, kept at one or more
    logic        crc     = 1'b0;
    logic        full    = 1'b0;
    logic        unl_go  = 1'b0;
    logic        flip    = 1'b0;
    logic [10:0] unl_len = 11'h000;
    int          wait_cnt;

    // one answer per request after lat+1 cycles, repeated while it stands
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt <= '0;
            wait_cnt <= 0;
        end else begin
            evt <= '0;
            evt.fifo_full <= full;
            evt.unload_done <= unl_go;
            evt.toggle_flip <= flip;
            evt.unload_len <= unl_len;
            if (mode == 3'h0 || !(ctl.in_request || ctl.send_stall)) begin
                wait_cnt <= 0;
            end else if (wait_cnt < lat) begin
                wait_cnt <= wait_cnt + 1;
            end else begin
                wait_cnt <= 0;
                if (ctl.send_stall) begin
                    evt.stall_sent <= 1'b1;
                end else begin
                    case (mode)
                        3'h1: begin
                            evt.rx_pkt <= 1'b1;
                            evt.rx_crc_err <= crc;
                        end
                        3'h2: evt.nak_rcvd <= 1'b1;
                        3'h3: evt.no_data <= 1'b1;
                        default: evt.stall_rcvd <= 1'b1;
                    endcase
                end
            end
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the receive endpoint control block
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    localparam logic [31:0] A_L = urx_pkg::CSRL_ADDR;
    localparam logic [31:0] A_H = urx_pkg::CSRH_ADDR;
    localparam logic [31:0] A_M = urx_pkg::MAXP_ADDR;
    localparam logic [31:0] A_C = urx_pkg::CFG_ADDR;
    typedef struct packed { logic [31:0] a; logic [31:0] d; logic [31:0] e; } urx_row_t;

    logic              hclk = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel = 1'b0;
    logic [31:0]       haddr = 32'h0;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [2:0]        hsize = 3'h2;
    logic [31:0]       hwdata = 32'h0;
    logic              hready;
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    urx_pkg::urx_evt_t evt;
    urx_pkg::urx_ctl_t ctl;
    int                err_total = 0;
    int                compares = 0;
    urx_row_t          rows [5] = '{
        '{A_L, 32'h0000_00ef, 32'h0000_0020}, '{A_L, 32'h0000_0000, 32'h0000_0000},
        '{A_M, 32'hffff_ffff, 32'h0000_07ff}, '{A_M, 32'h0000_0040, 32'h0000_0040},
        '{32'h0000_0600, 32'hffff_ffff, 32'h0000_0000}};

    always #4 hclk = ~hclk;
    assign hready = hreadyout; // single slave drives the bus ready

    urx_rx_ep_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt), .ctl(ctl));
    urx_usb_model u_usb (.hclk(hclk), .hresetn(hresetn), .ctl(ctl), .evt(evt));

    task automatic complete_run;
        $display("counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic timeout;
        err_total++;
        complete_run();
    endtask

    // next edge with hready high, bounded so a stuck slave cannot hang us
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) timeout();
            @(posedge hclk);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= 1'b1; htrans <= urx_pkg::HTRANS_NSEQ;
        wait_rdy();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wait_rdy();
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= 1'b0; htrans <= urx_pkg::HTRANS_NSEQ;
        wait_rdy();
        hsel <= 1'b0; htrans <= 2'h0;
        wait_rdy();
        d = hrdata;
    endtask

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask

    // reads until the masked bits are all set; flags arrive after the peer delay
    task automatic poll(input logic [31:0] a, input logic [7:0] m);
        logic [31:0] d;
        int n;
        n = 0;
        rd(a, d);
        while ((d[7:0] & m) !== m) begin
            n++;
            if (n > 60) timeout();
            rd(a, d);
        end
    endtask

    task automatic get_ready;
        u_usb.mode <= 3'h1;
        wr(A_L, 32'h20);
        poll(A_L, 8'h01);
        u_usb.mode <= 3'h0;
    endtask

    task automatic unload(input logic [10:0] len);
        @(posedge hclk);
        u_usb.unl_go <= 1'b1; u_usb.unl_len <= len;
        @(posedge hclk);
        u_usb.unl_go <= 1'b0;
        chk(A_L, {31'h0, len != 11'h040});
    endtask

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        chk(A_L, 32'h0);
        chk(A_H, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(rows[i].a, rows[i].e);
        end
        $display("done: register table");
        wr(A_C, 32'h1);
        u_usb.lat <= 3;
        get_ready();
        chk(A_L, 32'h01);
        u_usb.full <= 1'b1;
        chk(A_L, 32'h03);
        u_usb.full <= 1'b0;
        wr(A_L, 32'h11);
        chk(A_L, 32'h00);
        $display("done: host packet and discard");
        u_usb.lat <= 1;
        wr(A_H, 32'h80);
        get_ready();
        unload(11'h03f);
        unload(11'h040);
        get_ready();
        wr(A_H, 32'h40);
        wr(A_L, 32'h00);
        chk(A_L, 32'h20);
        wr(A_H, 32'h00);
        $display("done: auto clear and auto request");
        u_usb.mode <= 3'h3;
        wr(A_L, 32'h20);
        poll(A_L, 8'h04);
        u_usb.mode <= 3'h0;
        chk(A_L, 32'h24);
        wr(A_C, 32'h3);
        chk(A_L, 32'h20);
        wr(A_C, 32'h1);
        wr(A_L, 32'h00);
        chk(A_L, 32'h00);
        wr(A_C, 32'h301);
        u_usb.mode <= 3'h2;
        wr(A_L, 32'h20);
        poll(A_L, 8'h08);
        u_usb.mode <= 3'h0;
        `CHK(ctl.in_request, 1'b0)
        chk(A_L, 32'h28);
        wr(A_L, 32'h00);
        $display("done: retry and nak limit");
        wr(A_C, 32'h3);
        u_usb.mode <= 3'h3;
        wr(A_L, 32'h20);
        chk(A_L, 32'h20);
        chk(A_L, 32'h20);
        u_usb.crc <= 1'b1;
        get_ready();
        u_usb.crc <= 1'b0;
        chk(A_L, 32'h09);
        wr(A_L, 32'h08);
        chk(A_L, 32'h00);
        $display("done: isochronous host");
        wr(A_C, 32'h1);
        u_usb.mode <= 3'h4;
        wr(A_L, 32'h20);
        poll(A_L, 8'h40);
        u_usb.mode <= 3'h0;
        wr(A_L, 32'h00);
        chk(A_L, 32'h00);
        wr(A_C, 32'h0);
        u_usb.mode <= 3'h1;
        wr(A_L, 32'h20);
        poll(A_L, 8'h40);
        chk(A_L, 32'h60);
        u_usb.mode <= 3'h0;
        wr(A_L, 32'h00);
        chk(A_L, 32'h00);
        wr(A_C, 32'h2);
        wr(A_L, 32'h20);
        @(posedge hclk);
        `CHK(ctl.send_stall, 1'b0)
        $display("done: stall handling");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk(A_L, 32'h0);
        chk(A_M, 32'h0);
        @(posedge hclk);
        u_usb.flip <= 1'b1;
        @(posedge hclk);
        u_usb.flip <= 1'b0;
        chk(A_H, 32'h2);
        wr(A_L, 32'h80);
        chk(A_H, 32'h0);
        $display("done: second reset");
        complete_run();
    end
endmodule
